// File: logic/scdc_pkg.sv
package scdc_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [15:0] ADDR_MODE = 16'h0110;
  localparam logic [15:0] ADDR_SFINE = 16'h0111;
  localparam logic [15:0] ADDR_FINE = 16'h0112;
  localparam logic [15:0] ADDR_STATUS = 16'h011b;
  localparam logic [15:0] ADDR_SYNC_CTRL = 16'h010a;
  localparam logic [15:0] ADDR_DIV_OFFSET = 16'h010b;
  localparam logic [15:0] ADDR_PHASE = 16'h0129;
  // field layout
  localparam int MODE_W = 3;
  localparam int STEP_W = 8;
  localparam int PHASE_W = 4;
  localparam int ALIGN_EN_BIT = 7;
  localparam int NEG_SKEW_LSB = 2;
  localparam int POS_SKEW_LSB = 0;
  localparam int CLK_DET_BIT = 0;
  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] SFINE_RST = 8'h00;
  localparam logic [7:0] FINE_RST = 8'hc0;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [3:0] PHASE_RST = 4'h0;
  // step limits
  localparam logic [7:0] FINE_MAX_FULL = 8'hc0;
  localparam logic [7:0] FINE_MAX_RESTR = 8'h10;
  localparam logic [7:0] SFINE_MAX = 8'h80;
  // step sizes in femtoseconds
  localparam int FINE_STEP_FS = 1725;
  localparam int SFINE_STEP_FS = 250;
  // delay modes, one-hot decoded from the 3-bit field
  typedef enum logic [4:0] {
    SCDC_OFF = 5'h01,
    SCDC_FINE_LIM = 5'h02,
    SCDC_FINE_LJ = 5'h04,
    SCDC_FINE_FULL = 5'h08,
    SCDC_FINE_SFINE = 5'h10
  } scdc_mode_t;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_FINE16 = 3'h2;
  localparam logic [2:0] MODE_FINE16_LJ = 3'h3;
  localparam logic [2:0] MODE_FINE192 = 3'h4;
  localparam logic [2:0] MODE_BOTH = 3'h6;
endpackage

// File: logic/scdc_mode_decode.sv
`timescale 1ns/1ps
// turns the raw mode field and step counts into the steps actually applied
module scdc_mode_decode (
  // settings
  input wire logic [2:0] mode,
  input wire logic [7:0] fine_steps,
  input wire logic [7:0] sfine_steps,
  // applied delay
  output scdc_pkg::scdc_mode_t mode_oh,
  output logic [7:0] fine_applied,
  output logic [7:0] sfine_applied,
  output logic mode_reserved,
  output logic range_error
);
  always_comb begin
    mode_oh = scdc_pkg::SCDC_OFF;
    fine_applied = 8'h00;
    sfine_applied = 8'h00;
    mode_reserved = 1'b0;
    range_error = 1'b0;
    case (mode)
      scdc_pkg::MODE_NONE: begin
        mode_oh = scdc_pkg::SCDC_OFF;
      end
      scdc_pkg::MODE_FINE16: begin
        mode_oh = scdc_pkg::SCDC_FINE_LIM;
        fine_applied = fine_steps;
        sfine_applied = sfine_steps;
        range_error = (fine_steps > scdc_pkg::FINE_MAX_RESTR)
          || (sfine_steps > scdc_pkg::SFINE_MAX);
      end
      scdc_pkg::MODE_FINE16_LJ: begin
        mode_oh = scdc_pkg::SCDC_FINE_LJ;
        fine_applied = fine_steps;
        range_error = fine_steps > scdc_pkg::FINE_MAX_RESTR;
      end
      scdc_pkg::MODE_FINE192: begin
        mode_oh = scdc_pkg::SCDC_FINE_FULL;
        fine_applied = fine_steps;
        range_error = fine_steps > scdc_pkg::FINE_MAX_FULL;
      end
      scdc_pkg::MODE_BOTH: begin
        mode_oh = scdc_pkg::SCDC_FINE_SFINE;
        fine_applied = fine_steps;
        sfine_applied = sfine_steps;
        range_error = (fine_steps > scdc_pkg::FINE_MAX_FULL)
          || (sfine_steps > scdc_pkg::SFINE_MAX);
      end
      default: begin
        // reserved codes: safest is to apply no delay
        mode_reserved = 1'b1;
      end
    endcase
  end
endmodule

// File: logic/scdc_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin-level status
module scdc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  // first stage is read only by the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// File: logic/scdc_top.sv
`timescale 1ns/1ps
module scdc_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // status pins from the analog side
  input wire logic clk_detect,
  input wire logic [3:0] captured_phase,
  // delay line controls
  output logic [7:0] fine_delay,
  output logic [7:0] superfine_delay,
  output logic [4:0] delay_mode,
  output logic [15:0] delay_fs,
  output logic mode_reserved,
  output logic range_error
);
  logic [2:0] mode_q;
  logic [7:0] sfine_q;
  logic [7:0] fine_q;
  logic [7:0] sync_ctrl_q;
  logic [3:0] phase_q;
  logic [3:0] offset_q;
  logic [3:0] offset_d;
  logic clk_det_s;
  logic [3:0] cap_phase_s;
  scdc_pkg::scdc_mode_t mode_oh;
  logic [7:0] fine_app;
  logic [7:0] sfine_app;
  logic res_c;
  logic rng_c;
  logic [15:0] delay_d;

  // write decode shared between processes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  // pins cross into mclk through two flops
  scdc_sync2 #(.WIDTH(1)) u_sync_det (
    .mclk(mclk),
    .rst(rst),
    .din(clk_detect),
    .dout(clk_det_s)
  );
  scdc_sync2 #(.WIDTH(4)) u_sync_phase (
    .mclk(mclk),
    .rst(rst),
    .din(captured_phase),
    .dout(cap_phase_s)
  );

  // mode field, upper bits never stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= scdc_pkg::MODE_RST;
    end else if (wr && hit(addr, scdc_pkg::ADDR_MODE)) begin
      mode_q <= wdata[2:0];
    end
  end

  // step counts stored as written; range is software's job
  always_ff @(posedge mclk) begin
    if (rst) begin
      sfine_q <= scdc_pkg::SFINE_RST;
      fine_q <= scdc_pkg::FINE_RST;
    end else begin
      if (wr && hit(addr, scdc_pkg::ADDR_SFINE)) begin
        sfine_q <= wdata;
      end
      if (wr && hit(addr, scdc_pkg::ADDR_FINE)) begin
        fine_q <= wdata;
      end
    end
  end

  // sysref alignment control and phase register
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_ctrl_q <= scdc_pkg::SYNC_CTRL_RST;
      phase_q <= scdc_pkg::PHASE_RST;
    end else begin
      if (wr && hit(addr, scdc_pkg::ADDR_SYNC_CTRL)) begin
        sync_ctrl_q <= wdata;
      end
      if (wr && hit(addr, scdc_pkg::ADDR_PHASE)) begin
        phase_q <= wdata[3:0];
      end
    end
  end

  // divider offset status selection
  always_comb begin
    offset_d = 4'h0;
    if (sync_ctrl_q[scdc_pkg::ALIGN_EN_BIT]) begin
      if (sync_ctrl_q[3:0] == 4'h0) begin
        offset_d = phase_q;
      end else begin
        offset_d = cap_phase_s;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      offset_q <= 4'h0;
    end else begin
      offset_q <= offset_d;
    end
  end

  scdc_mode_decode u_dec (
    .mode(mode_q),
    .fine_steps(fine_q),
    .sfine_steps(sfine_q),
    .mode_oh(mode_oh),
    .fine_applied(fine_app),
    .sfine_applied(sfine_app),
    .mode_reserved(res_c),
    .range_error(rng_c)
  );

  // total delay in units of 10 fs: fine*1725 fs plus superfine*250 fs
  // dividing by ten keeps the full-range sum (363200 fs) inside 16 bits
  always_comb begin
    delay_d = 16'((32'(fine_app) * 32'(scdc_pkg::FINE_STEP_FS)
      + 32'(sfine_app) * 32'(scdc_pkg::SFINE_STEP_FS)) / 32'd10);
  end

  // registered controls toward the delay line
  always_ff @(posedge mclk) begin
    if (rst) begin
      fine_delay <= 8'h00;
      superfine_delay <= 8'h00;
      delay_mode <= 5'h01;
      delay_fs <= 16'h0000;
      mode_reserved <= 1'b0;
      range_error <= 1'b0;
    end else begin
      fine_delay <= fine_app;
      superfine_delay <= sfine_app;
      delay_mode <= mode_oh;
      delay_fs <= delay_d;
      mode_reserved <= res_c;
      range_error <= rng_c;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        scdc_pkg::ADDR_MODE: rdata <= {5'h00, mode_q};
        scdc_pkg::ADDR_SFINE: rdata <= sfine_q;
        scdc_pkg::ADDR_FINE: rdata <= fine_q;
        scdc_pkg::ADDR_STATUS: rdata <= {7'h00, clk_det_s};
        scdc_pkg::ADDR_SYNC_CTRL: rdata <= sync_ctrl_q;
        scdc_pkg::ADDR_DIV_OFFSET: rdata <= {4'h0, offset_q};
        scdc_pkg::ADDR_PHASE: rdata <= {4'h0, phase_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // checks
  sequence mode_write_s(logic [2:0] m);
    wr && addr == scdc_pkg::ADDR_MODE && wdata[2:0] == m;
  endsequence
  sequence reg_write_s(logic [15:0] a);
    wr && addr == a;
  endsequence
  sequence reg_read_s(logic [15:0] a);
    rd && addr == a;
  endsequence

  no_delay_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h0 |=> fine_delay == 8'h00 && superfine_delay == 8'h00)
    else $error("delay applied in mode zero");
  fine16_a: assert property (@(posedge mclk) disable iff (rst)
    mode_write_s(3'h2) ##1 !wr |=> fine_delay == fine_q)
    else $error("fine delay not applied in mode two");
  lowjit_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h3 |=> delay_mode == 5'h04 && superfine_delay == 8'h00)
    else $error("low jitter mode wrong");
  fine192_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h4 |=> superfine_delay == 8'h00 && fine_delay == $past(fine_q))
    else $error("full fine mode wrong");
  both_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h6 |=> superfine_delay == $past(sfine_q))
    else $error("superfine missing in mode six");
  sfine_gate_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q != 3'h2 && mode_q != 3'h6 |=> superfine_delay == 8'h00)
    else $error("superfine used outside its modes");
  fine_reset_a: assert property (@(posedge mclk)
    rst |=> fine_q == 8'hc0 && mode_q == 3'h0)
    else $error("bad reset value");
  rsvd_read_a: assert property (@(posedge mclk) disable iff (rst)
    rd && addr == scdc_pkg::ADDR_MODE |=> rdata[7:3] == 5'h00)
    else $error("mode reserved bits nonzero");
  status_read_a: assert property (@(posedge mclk) disable iff (rst)
    rd && addr == scdc_pkg::ADDR_STATUS |=> rdata[7:1] == 7'h00)
    else $error("status reserved bits nonzero");
  offset_a: assert property (@(posedge mclk) disable iff (rst)
    sync_ctrl_q[7] && sync_ctrl_q[3:0] == 4'h0 && $stable(phase_q)
    && $stable(sync_ctrl_q) |=> offset_q == $past(phase_q))
    else $error("offset does not follow phase register");
  reserved_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h5 |=> mode_reserved && fine_delay == 8'h00)
    else $error("reserved mode not flagged");

  // register storage and reset
  mode_store_a: assert property (@(posedge mclk) disable iff (rst)
    reg_write_s(scdc_pkg::ADDR_MODE) |=> mode_q == 3'($past(wdata)))
    else $error("mode write not stored");
  sfine_store_a: assert property (@(posedge mclk) disable iff (rst)
    reg_write_s(scdc_pkg::ADDR_SFINE) |=> sfine_q == $past(wdata))
    else $error("superfine write not stored");
  fine_store_a: assert property (@(posedge mclk) disable iff (rst)
    reg_write_s(scdc_pkg::ADDR_FINE) |=> fine_q == $past(wdata))
    else $error("fine write not stored");
  mode_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !wr |=> $stable(mode_q))
    else $error("mode changed without a write");
  step_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !wr |=> $stable(fine_q) && $stable(sfine_q))
    else $error("step count changed without a write");
  sfine_rst_a: assert property (@(posedge mclk)
    rst |=> sfine_q == 8'h00 && delay_fs == 16'h0000)
    else $error("superfine or total delay not cleared by reset");
  out_rst_a: assert property (@(posedge mclk)
    rst |=> delay_mode == 5'h01 && !mode_reserved && !range_error)
    else $error("outputs not idle after reset");

  // applied delay per mode
  fine_gate_a: assert property (@(posedge mclk) disable iff (rst)
    !(mode_q inside {3'h2, 3'h3, 3'h4, 3'h6}) |=> fine_delay == 8'h00)
    else $error("fine delay used outside its modes");
  fine_apply_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q inside {3'h2, 3'h3, 3'h4, 3'h6} |=> fine_delay == $past(fine_q))
    else $error("fine delay not applied in its modes");
  lim_mode_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h2 |=> delay_mode == 5'h02 && superfine_delay == $past(sfine_q))
    else $error("restricted fine mode wrong");
  full_mode_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h4 |=> delay_mode == 5'h08)
    else $error("full fine mode not selected");
  both_mode_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h6 |=> delay_mode == 5'h10 && fine_delay == $past(fine_q))
    else $error("combined mode wrong");
  off_mode_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h0 |=> delay_mode == 5'h01 && delay_fs == 16'h0000)
    else $error("mode zero shows a delay");
  rsvd_all_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q inside {3'h1, 3'h5, 3'h7} |=> mode_reserved && delay_fs == 16'h0000)
    else $error("reserved code applies a delay");
  rsvd_none_a: assert property (@(posedge mclk) disable iff (rst)
    !(mode_q inside {3'h1, 3'h5, 3'h7}) |=> !mode_reserved)
    else $error("listed mode flagged as reserved");

  // totals worked out from the step sizes: 1.725 ps fine, 0.25 ps superfine
  full_sum_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h4 && fine_q == 8'hc0 |=> delay_fs == 16'h8160) // 331.2 ps
    else $error("full fine total wrong");
  both_sum_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h6 && fine_q == 8'h10 && sfine_q == 8'h80 |=> delay_fs == 16'h1748)
    else $error("fine plus superfine total wrong");
  lj_sum_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h3 && fine_q == 8'h10 |=> delay_fs == 16'h0ac8) // 27.6 ps
    else $error("low jitter total wrong");

  // range flag per mode
  lim_range_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h2 && fine_q > 8'h10 |=> range_error)
    else $error("restricted fine overrange not flagged");
  lim_ok_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h2 && fine_q <= 8'h10 && sfine_q <= 8'h80 |=> !range_error)
    else $error("restricted fine in range flagged");
  lj_range_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h3 && fine_q > 8'h10 |=> range_error)
    else $error("low jitter overrange not flagged");
  lj_ok_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h3 && fine_q <= 8'h10 |=> !range_error)
    else $error("low jitter in range flagged");
  full_range_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h4 && fine_q > 8'hc0 |=> range_error)
    else $error("full fine overrange not flagged");
  full_ok_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h4 && fine_q <= 8'hc0 |=> !range_error)
    else $error("full fine in range flagged");
  sfine_range_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == 3'h2 || mode_q == 3'h6) && sfine_q > 8'h80 |=> range_error)
    else $error("superfine overrange not flagged");
  both_ok_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h6 && fine_q <= 8'hc0 && sfine_q <= 8'h80 |=> !range_error)
    else $error("combined mode in range flagged");
  off_range_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == 3'h0 |=> !range_error)
    else $error("range flagged with no delay");

  // register readback, one cycle after the strobe
  mode_rb_a: assert property (@(posedge mclk) disable iff (rst)
    reg_read_s(scdc_pkg::ADDR_MODE) |=> rdata[2:0] == $past(mode_q))
    else $error("mode readback wrong");
  sfine_rb_a: assert property (@(posedge mclk) disable iff (rst)
    reg_read_s(scdc_pkg::ADDR_SFINE) |=> rdata == $past(sfine_q))
    else $error("superfine readback wrong");
  fine_rb_a: assert property (@(posedge mclk) disable iff (rst)
    reg_read_s(scdc_pkg::ADDR_FINE) |=> rdata == $past(fine_q))
    else $error("fine readback wrong");
  status_rb_a: assert property (@(posedge mclk) disable iff (rst)
    reg_read_s(scdc_pkg::ADDR_STATUS) |=> rdata[0] == $past(clk_det_s))
    else $error("clock detect readback wrong");
  offset_rb_a: assert property (@(posedge mclk) disable iff (rst)
    reg_read_s(scdc_pkg::ADDR_DIV_OFFSET) |=> rdata == {4'h0, $past(offset_q)})
    else $error("divider offset readback wrong");

  // divider offset source selection
  offset_off_a: assert property (@(posedge mclk) disable iff (rst)
    !sync_ctrl_q[7] |=> offset_q == 4'h0)
    else $error("offset reported with alignment off");
  offset_cap_a: assert property (@(posedge mclk) disable iff (rst)
    sync_ctrl_q[7] && sync_ctrl_q[3:0] != 4'h0 |=> offset_q == $past(cap_phase_s))
    else $error("offset does not follow captured phase");
endmodule

// File: tb/sample_clock_delay_control_tb.sv
`timescale 1ns/1ps
module sample_clock_delay_control_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_detect = 1'b0;
  logic [3:0] captured_phase = 4'h0;
  logic [7:0] rdata, fine_delay, superfine_delay;
  logic [4:0] delay_mode;
  logic [15:0] delay_fs;
  logic mode_reserved, range_error;
  logic [3:0] ph;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] cf [4] = '{8'h10, 8'h11, 8'hc0, 8'hff};
  logic [7:0] cs [4] = '{8'h80, 8'h81, 8'h00, 8'hff};

  scdc_top dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .clk_detect(clk_detect), .captured_phase(captured_phase),
    .fine_delay(fine_delay), .superfine_delay(superfine_delay), .delay_mode(delay_mode),
    .delay_fs(delay_fs), .mode_reserved(mode_reserved), .range_error(range_error));

  // 50 MHz
  always #10 mclk = ~mclk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one-cycle strobes launched right after an edge
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp}, what);
  endtask

  // expected applied delay from mode and step counts
  function automatic logic [7:0] exp_fine(input logic [2:0] md, input logic [7:0] fv);
    return (md inside {3'h2, 3'h3, 3'h4, 3'h6}) ? fv : 8'h00;
  endfunction

  function automatic logic [7:0] exp_sfine(input logic [2:0] md, input logic [7:0] sv);
    return (md inside {3'h2, 3'h6}) ? sv : 8'h00;
  endfunction

  function automatic logic [4:0] exp_oh(input logic [2:0] md);
    case (md)
      3'h2: return 5'h02;
      3'h3: return 5'h04;
      3'h4: return 5'h08;
      3'h6: return 5'h10;
      default: return 5'h01;
    endcase
  endfunction

  function automatic logic exp_rng(input logic [2:0] md, input logic [7:0] fv,
      input logic [7:0] sv);
    case (md)
      3'h2: return (fv > 8'h10) || (sv > 8'h80);
      3'h3: return fv > 8'h10;
      3'h4: return fv > 8'hc0;
      3'h6: return (fv > 8'hc0) || (sv > 8'h80);
      default: return 1'b0;
    endcase
  endfunction

  // program a setting, let it settle, then compare outputs and readback
  task automatic run_case(input logic [2:0] md, input logic [7:0] fv, input logic [7:0] sv);
    logic [7:0] ef, es;
    ef = exp_fine(md, fv);
    es = exp_sfine(md, sv);
    reg_wr(16'h0111, sv);
    reg_wr(16'h0112, fv);
    reg_wr(16'h0110, {5'($urandom), md});
    repeat (3) @(posedge mclk);
    #1;
    check({8'h00, fine_delay}, {8'h00, ef}, "fine");
    check({8'h00, superfine_delay}, {8'h00, es}, "sfine");
    check({11'h000, delay_mode}, {11'h000, exp_oh(md)}, "mode");
    check(delay_fs, 16'((32'(ef) * 1725 + 32'(es) * 250) / 10), "fs");
    check({15'h0, mode_reserved}, {15'h0, md inside {3'h1, 3'h5, 3'h7}}, "rsv");
    check({15'h0, range_error}, {15'h0, exp_rng(md, fv, sv)}, "range");
    reg_rd(16'h0110, {5'h00, md}, "mode rb");
    reg_rd(16'h0112, fv, "fine rb");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog at 10k cycles, about ten times the expected run
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h5591));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({11'h000, delay_mode}, 16'h0001, "rst mode");
    check(delay_fs, 16'h0000, "rst fs");
    reg_rd(16'h0110, 8'h00, "rst mode");
    reg_rd(16'h0111, 8'h00, "rst sfine");
    reg_rd(16'h0112, 8'hc0, "rst fine");
    reg_rd(16'h011b, 8'h00, "rst status");
    // every mode code against boundary step counts
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) begin
        run_case(3'(i), cf[j], cs[j]);
      end
    end
    repeat (30) begin
      run_case(3'($urandom), 8'($urandom), 8'($urandom));
    end
    // status: reserved bits stay zero and ignore writes
    @(posedge mclk);
    clk_detect <= 1'b1;
    reg_wr(16'h011b, 8'hff);
    repeat (3) @(posedge mclk);
    reg_rd(16'h011b, 8'h01, "status");
    reg_rd(16'h0200, 8'h00, "unmapped");
    // divider offset follows the phase register when both windows are zero
    ph = 4'($urandom);
    reg_wr(16'h0129, {4'h0, ph});
    reg_wr(16'h010a, 8'h80);
    repeat (3) @(posedge mclk);
    reg_rd(16'h010b, {4'h0, ph}, "offset phase");
    @(posedge mclk);
    captured_phase <= ~ph;
    reg_wr(16'h010a, 8'h85);
    repeat (4) @(posedge mclk);
    reg_rd(16'h010b, {4'h0, ~ph}, "offset captured");
    reg_wr(16'h010a, 8'h05);
    repeat (3) @(posedge mclk);
    reg_rd(16'h010b, 8'h00, "offset off");
    // reset again in mid-run, after a nonzero setting
    run_case(3'h6, 8'h20, 8'h40);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    reg_rd(16'h0112, 8'hc0, "rerst fine");
    reg_rd(16'h0110, 8'h00, "rerst mode");
    #1;
    check({8'h00, fine_delay}, 16'h0000, "rerst fine out");
    print_verdict();
  end
endmodule
